// ---- core/supervisor_watchdog.sv ----
// Supervisory watchdog with APB register access
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/10ps
module supervisor_watchdog
    import supervisor_watchdog_pkg::*;
#(
    parameter int unsigned TICK_CYCLES    = TICK_CYCLES_DEFAULT,
    parameter int unsigned LONG_WINDOW_MS = LONG_WINDOW_MS_DEFAULT
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic [2:0]  device_mode,
    input  wire logic        reset_out_released,
    input  wire logic        sw_dev_mode,
    input  wire logic        bus_wake,
    output logic             wd_reset_req,
    output logic             supervisor_failure_bits_safe_sel,
    output logic             watchdog_running
);

    // =========================================================
    // Parameter checks
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES must lie in 1..65536");
    end
    if (LONG_WINDOW_MS < 1 || LONG_WINDOW_MS * TICKS_PER_MS >= (1 << COUNT_WIDTH)) begin : g_bad_long
        $error("LONG_WINDOW_MS does not fit the window counter");
    end

    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [COUNT_WIDTH-1:0] LONG_TICKS = COUNT_WIDTH'(LONG_WINDOW_MS * TICKS_PER_MS);

    function automatic logic [COUNT_WIDTH-1:0] period_ticks(input logic [2:0] sel);
        period_ticks = COUNT_WIDTH'(PERIOD_MS[sel] * TICKS_PER_MS);
    endfunction

    function automatic logic [COUNT_WIDTH-1:0] closed_ticks(input logic [2:0] sel);
        logic [31:0] full;
        full = 32'(period_ticks(sel));
        closed_ticks = COUNT_WIDTH'((full * CLOSED_PERCENT) / 100);
    endfunction

    // =========================================================
    // State
    wd_state_type            state_reg;
    wd_state_type            state_next;
    logic                    type_reg;
    logic [2:0]              period_reg;
    logic                    stop_sv_reg;
    logic                    stop_sv_next;
    logic                    stop_hw_reg;
    logic                    stop_hw_next;
    logic                    bus_wake_en_reg;
    logic                    fail_safe_sel_reg;
    logic [1:0]              fail_bits_reg;
    logic [1:0]              fail_bits_next;
    logic                    serial_fail_reg;
    logic                    fs_by_wd_reg;
    logic                    released_prev_reg;
    logic [2:0]              mode_prev_reg;
    logic [15:0]             presc_reg;
    logic [COUNT_WIDTH-1:0]  elapsed_reg;
    logic [COUNT_WIDTH-1:0]  elapsed_next;
    logic                    reset_req_reg;
    logic [31:0]             prdata_reg;
    logic                    fail_event;
    logic                    clear_seq;
    logic                    start_long;

    // =========================================================
    // APB decode
    wire access      = psel & penable;
    wire hit_ctrl    = paddr == SUPERVISOR_CTRL_OFFSET;
    wire hit_hw      = paddr == HARDWARE_CTRL_OFFSET;
    wire hit_status  = paddr == STATUS_OFFSET;
    wire mapped      = hit_ctrl | hit_hw | hit_status;
    wire strobe_ok   = pstrb[1:0] == 2'b11;
    wire wr_ok       = access & pwrite & mapped & strobe_ok;
    wire wr_ctrl     = wr_ok & hit_ctrl;
    wire wr_hw       = wr_ok & hit_hw;
    wire wr_status   = wr_ok & hit_status;
    // Reserved bits take part exactly as written
    wire parity_ok   = ~^pwdata[DATA_BITS-1:0];
    wire good_ctrl   = wr_ctrl & parity_ok;
    wire bad_ctrl    = wr_ctrl & ~parity_ok;

    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | (pwrite & ~strobe_ok));
    assign prdata  = prdata_reg;

    // =========================================================
    // Mode and event decode
    wire mode_normal = device_mode == MODE_NORMAL;
    wire mode_stop   = device_mode == MODE_STOP;
    wire mode_off    = device_mode == MODE_SLEEP || device_mode == MODE_RESTART;
    wire prev_off    = mode_prev_reg == MODE_SLEEP || mode_prev_reg == MODE_RESTART;
    wire wake_normal = mode_normal & prev_off;
    wire stop_exit   = mode_normal & (mode_prev_reg == MODE_STOP);
    wire rst_release = reset_out_released & ~released_prev_reg;
    wire trigger     = good_ctrl & (mode_normal | mode_stop);
    wire cfg_update  = good_ctrl & mode_normal;
    wire running     = state_reg == WD_LONG || state_reg == WD_RUN;
    wire tick        = presc_reg == TICK_LAST;
    wire [COUNT_WIDTH-1:0] limit = (state_reg == WD_LONG) ? LONG_TICKS : period_ticks(period_reg);
    wire expire      = running & tick & (elapsed_reg + 1'b1 >= limit);
    // Closed window only in window type, never during the long window
    wire closed      = type_reg & (state_reg == WD_RUN) & (elapsed_reg < closed_ticks(period_reg));
    wire seq_bad     = stop_sv_reg & ~stop_hw_reg &
                       (cfg_update | (wr_hw & mode_normal & ~pwdata[STOP_HW_BIT]));

    assign wd_reset_req     = reset_req_reg;
    assign supervisor_failure_bits_safe_sel = fail_safe_sel_reg;
    assign watchdog_running = running;

    // =========================================================
    // Watchdog sequencing
    always_comb begin
        state_next   = state_reg;
        elapsed_next = (running && tick) ? elapsed_reg + 1'b1 : elapsed_reg;
        fail_event   = 1'b0;
        clear_seq    = 1'b0;
        start_long   = 1'b0;
        if (mode_off) begin
            state_next = WD_OFF;
        end else if (state_reg == WD_OFF) begin
            if (rst_release || wake_normal) begin
                start_long = 1'b1;
            end
        end else if (state_reg == WD_STOPPED) begin
            if (stop_exit || trigger || (bus_wake && bus_wake_en_reg && mode_stop)) begin
                start_long = 1'b1;
                clear_seq  = 1'b1;
            end
        end else if (trigger && closed) begin
            fail_event = 1'b1;
        end else if (trigger) begin
            state_next   = WD_RUN;
            elapsed_next = '0;
        end else if (expire) begin
            fail_event = 1'b1;
        end else if (mode_stop && stop_sv_reg && stop_hw_reg) begin
            state_next = WD_STOPPED;
        end
        if (fail_event && sw_dev_mode) begin
            fail_event = 1'b0;
            start_long = 1'b1;
        end else if (fail_event) begin
            state_next = WD_OFF;
        end
        if (start_long) begin
            state_next   = WD_LONG;
            elapsed_next = '0;
        end
    end

    // =========================================================
    // Stop-disable sequence bits
    always_comb begin
        stop_sv_next = stop_sv_reg;
        stop_hw_next = stop_hw_reg;
        if (clear_seq) begin
            stop_sv_next = 1'b0;
            stop_hw_next = 1'b0;
        end else if (seq_bad) begin
            stop_sv_next = 1'b0;
        end else if (cfg_update) begin
            stop_sv_next = pwdata[STOP_SV_BIT];
            if (pwdata[STOP_SV_BIT] && stop_hw_reg) begin
                stop_hw_next = 1'b0;
            end
        end else if (wr_hw && mode_normal) begin
            stop_hw_next = pwdata[STOP_HW_BIT] & stop_sv_reg;
        end
    end

    // =========================================================
    // Failure bits: a new failure wins over every clear
    always_comb begin
        fail_bits_next = fail_bits_reg;
        if (fail_event) begin
            fail_bits_next = (fail_bits_reg == 2'h3) ? 2'h3 : fail_bits_reg + 2'h1;
        end else if ((trigger && running) || state_next == WD_STOPPED
                     || device_mode == MODE_SLEEP
                     || (device_mode == MODE_FAIL_SAFE && !fs_by_wd_reg)) begin
            fail_bits_next = 2'h0;
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= WD_OFF;
            elapsed_reg <= '0;
            presc_reg   <= 16'h0000;
        end else begin
            state_reg   <= state_next;
            elapsed_reg <= elapsed_next;
            presc_reg   <= (tick || !running) ? 16'h0000 : presc_reg + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            type_reg          <= TYPE_RESET;
            period_reg        <= PERIOD_RESET;
            bus_wake_en_reg   <= BUS_WAKE_RESET;
            fail_safe_sel_reg <= FAIL_SAFE_RESET;
        end else if (cfg_update) begin
            type_reg   <= pwdata[TYPE_BIT];
            period_reg <= pwdata[PERIOD_LSB +: 3];
        end else if (wr_hw && mode_normal) begin
            bus_wake_en_reg   <= pwdata[BUS_WAKE_BIT];
            fail_safe_sel_reg <= pwdata[FAIL_SAFE_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_sv_reg       <= 1'b0;
            stop_hw_reg       <= 1'b0;
            fail_bits_reg     <= 2'h0;
            serial_fail_reg   <= 1'b0;
            fs_by_wd_reg      <= 1'b0;
            released_prev_reg <= 1'b0;
            mode_prev_reg     <= MODE_INIT;
            reset_req_reg     <= 1'b0;
        end else begin
            stop_sv_reg       <= stop_sv_next;
            stop_hw_reg       <= stop_hw_next;
            fail_bits_reg     <= fail_bits_next;
            // Parity error sets even in the cycle software clears the flag
            serial_fail_reg   <= bad_ctrl | (serial_fail_reg & ~(wr_status & pwdata[SERIAL_FAIL_BIT]));
            fs_by_wd_reg      <= (fail_event & fail_safe_sel_reg) | (fs_by_wd_reg & ~mode_normal);
            released_prev_reg <= reset_out_released;
            mode_prev_reg     <= device_mode;
            reset_req_reg     <= fail_event;
        end
    end

    // Read data is captured in the setup cycle, so the status view is one cycle old
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_reg <= 32'h0000_0000;
            if (hit_ctrl) begin
                prdata_reg[PERIOD_LSB +: 3] <= period_reg;
                prdata_reg[STOP_SV_BIT]     <= stop_sv_reg;
                prdata_reg[TYPE_BIT]        <= type_reg;
            end else if (hit_hw) begin
                prdata_reg[STOP_HW_BIT]     <= stop_hw_reg;
                prdata_reg[BUS_WAKE_BIT]    <= bus_wake_en_reg;
                prdata_reg[FAIL_SAFE_BIT]   <= fail_safe_sel_reg;
            end else if (hit_status) begin
                prdata_reg[FAIL_BITS_LSB +: 2] <= fail_bits_reg;
                prdata_reg[SERIAL_FAIL_BIT]    <= serial_fail_reg;
                prdata_reg[STATE_LSB +: 2]     <= state_reg;
                prdata_reg[CLOSED_BIT]         <= closed;
            end
        end
    end

    // =========================================================
    // Assertions
    parity_reject_a: assert property (@(posedge pclk) disable iff (!presetn)
        bad_ctrl |=> serial_fail_reg && $stable(period_reg) && $stable(type_reg))
        else $error("bad checksum write was not ignored");

    cfg_frozen_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_stop |=> $stable(type_reg) && $stable(period_reg))
        else $error("configuration changed in stop mode");

    hw_refused_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hw && !stop_sv_reg && !clear_seq) |=> !stop_hw_reg)
        else $error("hardware stop-disable bit set without control bit");

    closed_trigger_a: assert property (@(posedge pclk) disable iff (!presetn)
        (trigger && closed && !sw_dev_mode && !mode_off) |=> wd_reset_req && state_reg == WD_OFF)
        else $error("closed-window trigger did not fail");

    expiry_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
        (expire && !trigger && !sw_dev_mode && !mode_off) |=> wd_reset_req ##1 !wd_reset_req)
        else $error("expiry did not give a one-cycle reset request");

    dev_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        (expire && !trigger && sw_dev_mode && !mode_off) |=> state_reg == WD_LONG && !wd_reset_req
        && elapsed_reg == '0)
        else $error("development mode miss did not restart long window");

    service_restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        (trigger && running && !closed && !mode_off) |=> state_reg == WD_RUN && elapsed_reg == '0
        && fail_bits_reg == 2'h0)
        else $error("good trigger did not start a new period");

    release_long_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == WD_OFF && rst_release && !mode_off) |=> state_reg == WD_LONG)
        else $error("reset release did not start the long window");

    sleep_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (device_mode == MODE_SLEEP) [*2] |-> !running && fail_bits_reg == 2'h0)
        else $error("watchdog or failure bits alive in sleep");

    wake_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == WD_STOPPED && mode_stop && bus_wake && bus_wake_en_reg)
        |=> state_reg == WD_LONG && !stop_sv_reg && !stop_hw_reg)
        else $error("bus wake did not restart the watchdog");

    // Software clears the serial-failure flag by writing a one to it
    serial_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_status && pwdata[SERIAL_FAIL_BIT])
        |=> !serial_fail_reg)
        else $error("serial failure flag was not cleared");

    type_window_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_update && pwdata[TYPE_BIT])
        |=> type_reg)
        else $error("window type was not taken");

    type_timeout_a: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_update && !pwdata[TYPE_BIT])
        |=> !type_reg)
        else $error("time-out type was not taken");

    // Parking clears the failure count, so a stale count cannot survive a parked stop
    stop_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        (running && mode_stop && stop_sv_reg && stop_hw_reg && !trigger && !expire)
        |=> state_reg == WD_STOPPED && fail_bits_reg == 2'h0)
        else $error("stop entry did not park the watchdog");

    stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == WD_STOPPED && mode_stop && !trigger && !bus_wake)
        |=> state_reg == WD_STOPPED)
        else $error("parked watchdog left stop without cause");

    stop_trigger_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == WD_STOPPED && trigger)
        |=> state_reg == WD_LONG && !stop_sv_reg && !stop_hw_reg)
        else $error("trigger in stop did not restart the watchdog");

    seq_violation_a: assert property (@(posedge pclk) disable iff (!presetn)
        seq_bad
        |=> !stop_sv_reg)
        else $error("sequence violation kept the control enable bit");

    mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        mode_off
        |=> state_reg == WD_OFF)
        else $error("watchdog alive in sleep or restart");

    sleep_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == WD_OFF && wake_normal)
        |=> state_reg == WD_LONG)
        else $error("entering normal did not start the long window");

    // The count saturates so that repeated failures never wrap to zero
    fail_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        (fail_event && fail_bits_reg != 2'h3)
        |=> fail_bits_reg == $past(fail_bits_reg) + 2'h1)
        else $error("failure count did not advance");

    fail_safe_a: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_hw && mode_normal && pwdata[FAIL_SAFE_BIT])
        |=> supervisor_failure_bits_safe_sel)
        else $error("fail-safe select was not taken");

endmodule

// ---- core/supervisor_watchdog_pkg.sv ----
// Constants and types of the supervisory watchdog
package supervisor_watchdog_pkg;

    // =========================================================
    // Register map
    localparam logic [7:0] SUPERVISOR_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] HARDWARE_CTRL_OFFSET   = 8'h04;
    localparam logic [7:0] STATUS_OFFSET          = 8'h08;

    // Control register: bits 15..0 stand for frame bits 23..8, checksum on top
    localparam int unsigned PERIOD_LSB       = 0;
    localparam int unsigned STOP_SV_BIT      = 4;
    localparam int unsigned TYPE_BIT         = 5;
    localparam int unsigned CHECKSUM_BIT     = 15;
    localparam int unsigned DATA_BITS        = 16;
    // Hardware control register
    localparam int unsigned STOP_HW_BIT      = 0;
    localparam int unsigned BUS_WAKE_BIT     = 1;
    localparam int unsigned FAIL_SAFE_BIT    = 2;
    // Status register
    localparam int unsigned FAIL_BITS_LSB    = 0;
    localparam int unsigned SERIAL_FAIL_BIT  = 2;
    localparam int unsigned STATE_LSB        = 4;
    localparam int unsigned CLOSED_BIT       = 6;

    // =========================================================
    // Reset values
    localparam logic       TYPE_RESET        = 1'b0;
    localparam logic [2:0] PERIOD_RESET      = 3'h0;
    localparam logic       BUS_WAKE_RESET    = 1'b1;
    localparam logic       FAIL_SAFE_RESET   = 1'b0;

    // =========================================================
    // Device modes as presented by the mode controller
    localparam logic [2:0] MODE_INIT         = 3'h0;
    localparam logic [2:0] MODE_NORMAL       = 3'h1;
    localparam logic [2:0] MODE_STOP         = 3'h2;
    localparam logic [2:0] MODE_SLEEP        = 3'h3;
    localparam logic [2:0] MODE_RESTART      = 3'h4;
    localparam logic [2:0] MODE_FAIL_SAFE    = 3'h5;

    // =========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS    = 5;
    localparam int unsigned TICK_TIME_NS     = 1000;
    localparam int unsigned TICK_CYCLES_DEFAULT = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TICKS_PER_MS     = 1000000 / TICK_TIME_NS;
    localparam int unsigned PERIOD_MS [8]    = '{10, 20, 50, 100, 200, 500, 1000, 10000};
    localparam int unsigned CLOSED_PERCENT   = 60;
    localparam int unsigned LONG_WINDOW_MS_DEFAULT = 200;
    localparam int unsigned COUNT_WIDTH      = 24;

    typedef enum logic [1:0] {WD_OFF, WD_LONG, WD_RUN, WD_STOPPED} wd_state_type;

endpackage

// ---- tb/host_apb_model.sv ----
// Host microcontroller model driving the register bus of the watchdog
`timescale 1ns/10ps
module host_apb_model
    import supervisor_watchdog_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    output logic [3:0]       pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hf;
    end

    // =========================================================
    // Bus transfer: request held until pready is seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave needs; only the bench watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data never keeps its last value
        pwdata <= ~data;
    endtask

    // =========================================================
    // Control write with checksum; bad inverts it on purpose
    task automatic wr_ctrl(input logic [14:0] d, input logic bad);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, SUPERVISOR_CTRL_OFFSET, {16'h0, (^d) ^ bad, d}, r, e);
    endtask
endmodule

// ---- tb/tb_top.sv ----
// Self-checking testbench of the supervisory watchdog
`timescale 1ns/10ps
module tb_top
    import supervisor_watchdog_pkg::*;
;
    localparam int LW = TICKS_PER_MS;
    localparam int P0 = PERIOD_MS[0] * TICKS_PER_MS;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        reset_out_released, sw_dev_mode, bus_wake, wd_reset_req, supervisor_failure_bits_safe_sel, watchdog_running;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, lfsr_val;
    logic [3:0]  pstrb;
    logic [2:0]  device_mode;
    int          num_errors, cmp_count, m_fail, m_sf, m_state;

    supervisor_watchdog #(.TICK_CYCLES(1), .LONG_WINDOW_MS(1)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .device_mode(device_mode), .reset_out_released(reset_out_released), .sw_dev_mode(sw_dev_mode),
        .bus_wake(bus_wake), .wd_reset_req(wd_reset_req), .supervisor_failure_bits_safe_sel(supervisor_failure_bits_safe_sel),
        .watchdog_running(watchdog_running));
    host_apb_model host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

    // =========================================================
    // Helpers and reference model
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] exp_status();
        return 32'(m_fail | (m_sf << 2) | (m_state << 4));
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        // Status lags one cycle, so let it settle first
        repeat (2) @(posedge pclk);
        host.xfer(1'b0, a, 32'h0, rd, err);
        chk(rd & msk, exp);
    endtask
    task automatic trig(input logic [5:0] cfg, input logic bad);
        lfsr_val = lfsr(lfsr_val);
        host.wr_ctrl({lfsr_val[8:0], cfg}, bad);
        if (bad) m_sf = 1;
        else begin
            m_fail = 0;
            m_state = 2;
        end
    endtask
    task automatic wait_fail(input int lo, input int hi);
        int n;
        n = 0;
        // The pulse may already stand when the triggering write returns
        #1;
        while (wd_reset_req !== 1'b1 && n < hi) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(32'(n >= lo && wd_reset_req === 1'b1), 32'h1);
        m_fail = (m_fail < 3) ? m_fail + 1 : 3;
        m_state = 0;
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge pclk);
            #1;
            chk({31'h0, wd_reset_req}, 32'h0);
        end
    endtask
    task automatic relaunch();
        @(posedge pclk);
        reset_out_released <= 1'b0;
        @(posedge pclk);
        reset_out_released <= 1'b1;
        repeat (2) @(posedge pclk);
        #1;
        m_state = 1;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // =========================================================
    // Clock, watchdog and test sequence
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        // Sequence needs about 25000 cycles
        #300000;
        num_errors++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        device_mode = MODE_INIT;
        reset_out_released = 1'b0;
        sw_dev_mode = 1'b0;
        bus_wake = 1'b0;
        lfsr_val = 32'h82ad;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(SUPERVISOR_CTRL_OFFSET, 32'h0, '1);
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h2, '1);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        relaunch();
        chk({31'h0, watchdog_running}, 32'h1);
        wait_fail(LW - 20, LW + 20);
        chk({31'h0, supervisor_failure_bits_safe_sel}, 32'h0);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        $display("test 1 done");
        device_mode <= MODE_NORMAL;
        relaunch();
        trig(6'h01, 1'b1);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        rd_chk(SUPERVISOR_CTRL_OFFSET, 32'h0, 32'h3f);
        trig(6'h00, 1'b0);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        repeat (5000) @(posedge pclk);
        trig(6'h00, 1'b0);
        wait_fail(P0 - 20, P0 + 20);
        $display("test 2 done");
        relaunch();
        trig(6'h20, 1'b0);
        // Host waits past 0.8 of the period before serving
        repeat (8000) @(posedge pclk);
        trig(6'h20, 1'b0);
        quiet(3);
        rd_chk(STATUS_OFFSET, exp_status() | 32'h40, '1);
        trig(6'h20, 1'b0);
        wait_fail(0, 6);
        rd_chk(SUPERVISOR_CTRL_OFFSET, 32'h20, 32'h3f);
        $display("test 3 done");
        relaunch();
        host.xfer(1'b1, HARDWARE_CTRL_OFFSET, 32'h3, rd, err);
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h2, '1);
        trig(6'h30, 1'b0);
        host.xfer(1'b1, HARDWARE_CTRL_OFFSET, 32'h3, rd, err);
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h3, '1);
        device_mode <= MODE_STOP;
        m_state = 3;
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        trig(6'h20, 1'b0);
        m_state = 1;
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h2, '1);
        rd_chk(SUPERVISOR_CTRL_OFFSET, 32'h20, 32'h3f);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        $display("test 4 done");
        device_mode <= MODE_NORMAL;
        sw_dev_mode <= 1'b1;
        quiet(LW + 100);
        chk({31'h0, watchdog_running}, 32'h1);
        host.xfer(1'b0, 8'h0c, 32'h0, rd, err);
        chk({err, rd[30:0]}, 32'h80000000);
        trig(6'h10, 1'b0);
        // Clearing the hardware step breaks the sequence; fail-safe select is taken at once
        host.xfer(1'b1, HARDWARE_CTRL_OFFSET, 32'h6, rd, err);
        rd_chk(SUPERVISOR_CTRL_OFFSET, 32'h0, 32'h3f);
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h6, '1);
        chk({31'h0, supervisor_failure_bits_safe_sel}, 32'h1);
        trig(6'h10, 1'b0);
        host.xfer(1'b1, HARDWARE_CTRL_OFFSET, 32'h7, rd, err);
        device_mode <= MODE_STOP;
        m_state = 3;
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        @(posedge pclk);
        bus_wake <= 1'b1;
        @(posedge pclk);
        bus_wake <= 1'b0;
        m_state = 1;
        rd_chk(HARDWARE_CTRL_OFFSET, 32'h6, '1);
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        device_mode <= MODE_SLEEP;
        m_state = 0;
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        host.xfer(1'b1, STATUS_OFFSET, 32'h4, rd, err);
        m_sf = 0;
        device_mode <= MODE_NORMAL;
        m_state = 1;
        rd_chk(STATUS_OFFSET, exp_status(), '1);
        $display("test 5 done");
        close_out();
    end
endmodule
